// ==== rsts_pkg.sv ====
// constants, field layouts and carrier types of the relay self-test supervisor
// assumes a 20 MHz system clock and monitors that report magnitudes in mV and mA
package rsts_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TEST_PERIOD_S = 10;
    localparam int unsigned TEST_PERIOD_CYC = TEST_PERIOD_S * CLK_HZ;
    localparam int unsigned ALARM_PULSE_S = 5;
    localparam int unsigned ALARM_PULSE_CYC = ALARM_PULSE_S * CLK_HZ;

    // ------------------------------------------------------------------
    // register map and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] STATUS_OFS = 8'h00;
    localparam logic [7:0] MASK_OFS = 8'h04;
    localparam logic [7:0] CTRL_OFS = 8'h08;
    localparam logic [7:0] LIVE_OFS = 8'h0C;
    localparam int STAT_W = 17;
    localparam int WARN_LSB = 0;
    localparam int FAIL_LSB = 8;
    localparam int DIFF_BIT = 16;
    localparam int PROT_BIT = 16;
    localparam int DDIS_BIT = 17;
    localparam int ALRM_BIT = 18;
    localparam int CTRL_RUN_BIT = 0;
    localparam logic CTRL_RUN_RST = 1'b1;
    localparam logic [STAT_W-1:0] MASK_RST = 17'h00000;

    // ------------------------------------------------------------------
    // self-test indices and limits (mV)
    // ------------------------------------------------------------------
    localparam int NTEST = 6;
    localparam int T_CHOFS = 0;
    localparam int T_MOFS = 1;
    localparam int T_P5 = 2;
    localparam int T_REG5 = 3;
    localparam int T_P12 = 4;
    localparam int T_P15 = 5;
    localparam int NCHAN = 8;
    localparam logic [15:0] CHOFS_WARN_MV = 16'd30;
    localparam logic [15:0] MOFS_WARN_MV = 16'd20;
    localparam logic [15:0] MOFS_FAIL_MV = 16'd30;
    localparam logic [15:0] P5_WARN_LO = 16'd4800;
    localparam logic [15:0] P5_WARN_HI = 16'd5200;
    localparam logic [15:0] P5_FAIL_LO = 16'd4650;
    localparam logic [15:0] P5_FAIL_HI = 16'd5400;
    localparam logic [15:0] REGP_WARN_LO = 16'd4750;
    localparam logic [15:0] REGP_WARN_HI = 16'd5200;
    localparam logic [15:0] REGP_FAIL_LO = 16'd4500;
    localparam logic [15:0] REGP_FAIL_HI = 16'd5400;
    localparam logic [15:0] REGN_WARN_LO = 16'd4750;
    localparam logic [15:0] REGN_WARN_HI = 16'd5250;
    localparam logic [15:0] REGN_FAIL_LO = 16'd4500;
    localparam logic [15:0] REGN_FAIL_HI = 16'd5500;
    localparam logic [15:0] P12_WARN_LO = 16'd11500;
    localparam logic [15:0] P12_WARN_HI = 16'd12500;
    localparam logic [15:0] P12_FAIL_LO = 16'd11200;
    localparam logic [15:0] P12_FAIL_HI = 16'd14000;
    localparam logic [15:0] P15_WARN_LO = 16'd14400;
    localparam logic [15:0] P15_WARN_HI = 16'd15600;
    localparam logic [15:0] P15_FAIL_LO = 16'd14000;
    localparam logic [15:0] P15_FAIL_HI = 16'd16000;

    // ------------------------------------------------------------------
    // restraint flag limits (mA, degrees)
    // ------------------------------------------------------------------
    localparam logic [15:0] NSQ_PICKUP_MA = 16'd390;
    localparam logic [15:0] NSQ_DROPOUT_MA = 16'd14000;
    localparam logic [7:0] NSQ_ANGLE_DEG = 8'd83;
    localparam logic [7:0] NSQ_BLOCK_DEG = 8'd60;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NCHAN-1:0][15:0] chan_ofs_mv;
        logic [15:0] master_ofs_mv;
        logic [15:0] p5_mv;
        logic [15:0] reg_pos_mv;
        logic [15:0] reg_neg_mv;
        logic [15:0] p12_pos_mv;
        logic [15:0] p12_neg_mv;
        logic [15:0] p15_pos_mv;
        logic [15:0] p15_neg_mv;
    } rsts_meas_s;

    typedef struct packed {
        logic [15:0] local_ma;
        logic [15:0] remote_ma;
        logic signed [8:0] angle_deg;
    } rsts_nsq_s;

endpackage : rsts_pkg

// ==== rsts_top.sv ====
// relay self-test supervisor: limit checks, corrective actions, APB registers
// assumes monitor values are synchronous to ref_clk_i and hold steady between ticks
`timescale 1ns/1ps
module rsts_top #(
    parameter int unsigned TEST_PERIOD = rsts_pkg::TEST_PERIOD_CYC,
    parameter int unsigned ALARM_PULSE = rsts_pkg::ALARM_PULSE_CYC,
    parameter int N_OUT = 8
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire rsts_pkg::rsts_meas_s meas_i,
    input wire rsts_pkg::rsts_nsq_s nsq_i,
    input wire logic diff_hw_fail_i,
    input wire logic [N_OUT-1:0] out_req_i,
    input wire logic [5:0] diff_req_i,
    output logic [N_OUT-1:0] output_contacts_o,
    output logic [5:0] differential_output_contacts_o,
    output logic overcurrent_enable_o,
    output logic trip_close_enable_o,
    output logic enabled_led_o,
    output logic alarm_energize_o,
    output logic differential_protection_enabled_o,
    output logic differential_hardware_alarm_o,
    output logic status_report_o,
    output logic display_fail_o,
    output logic [2:0] display_code_o,
    output logic negseq_restraint_flag_o,
    output logic irq_o
);
    import rsts_pkg::*;

    if (TEST_PERIOD < 2 || ALARM_PULSE < 2 || N_OUT < 1) begin : g_chk
        $error("rsts_top: periods must be at least 2 cycles and N_OUT at least 1");
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic out_of(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        out_of = (v < lo) || (v > hi);
    endfunction : out_of

    function automatic logic [7:0] abs_deg(input logic signed [8:0] a);
        abs_deg = a[8] ? 8'(-a) : 8'(a);
    endfunction : abs_deg

    function automatic logic [2:0] first_set(input logic [NTEST-1:0] v);
        first_set = 3'h0;
        for (int i = NTEST - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 3'(i);
            end
        end
    endfunction : first_set

    // ------------------------------------------------------------------
    // test tick
    // ------------------------------------------------------------------
    logic [31:0] tick_cnt_q;
    logic tick_q;
    logic run_q;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !run_q) begin
            tick_cnt_q <= 32'h00000000;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == 32'(TEST_PERIOD - 1)) begin
            tick_cnt_q <= 32'h00000000;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h00000001;
            tick_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // limit checks
    // ------------------------------------------------------------------
    logic [NCHAN-1:0] chan_over;
    logic [NTEST-1:0] warn_raw;
    logic [NTEST-1:0] fail_raw;
    logic [NTEST-1:0] warn_c;

    for (genvar g = 0; g < NCHAN; g++) begin : g_chan
        assign chan_over[g] = meas_i.chan_ofs_mv[g] > CHOFS_WARN_MV;
    end

    always_comb begin
        warn_raw[T_CHOFS] = |chan_over;
        fail_raw[T_CHOFS] = 1'b0;
        warn_raw[T_MOFS] = meas_i.master_ofs_mv > MOFS_WARN_MV;
        fail_raw[T_MOFS] = meas_i.master_ofs_mv > MOFS_FAIL_MV;
        warn_raw[T_P5] = out_of(meas_i.p5_mv, P5_WARN_LO, P5_WARN_HI);
        fail_raw[T_P5] = out_of(meas_i.p5_mv, P5_FAIL_LO, P5_FAIL_HI);
        warn_raw[T_REG5] = out_of(meas_i.reg_pos_mv, REGP_WARN_LO, REGP_WARN_HI)
                         || out_of(meas_i.reg_neg_mv, REGN_WARN_LO, REGN_WARN_HI);
        fail_raw[T_REG5] = out_of(meas_i.reg_pos_mv, REGP_FAIL_LO, REGP_FAIL_HI)
                         || out_of(meas_i.reg_neg_mv, REGN_FAIL_LO, REGN_FAIL_HI);
        warn_raw[T_P12] = out_of(meas_i.p12_pos_mv, P12_WARN_LO, P12_WARN_HI)
                        || out_of(meas_i.p12_neg_mv, P12_WARN_LO, P12_WARN_HI);
        fail_raw[T_P12] = out_of(meas_i.p12_pos_mv, P12_FAIL_LO, P12_FAIL_HI)
                        || out_of(meas_i.p12_neg_mv, P12_FAIL_LO, P12_FAIL_HI);
        warn_raw[T_P15] = out_of(meas_i.p15_pos_mv, P15_WARN_LO, P15_WARN_HI)
                        || out_of(meas_i.p15_neg_mv, P15_WARN_LO, P15_WARN_HI);
        fail_raw[T_P15] = out_of(meas_i.p15_pos_mv, P15_FAIL_LO, P15_FAIL_HI)
                        || out_of(meas_i.p15_neg_mv, P15_FAIL_LO, P15_FAIL_HI);
        warn_c = warn_raw & ~fail_raw;
    end

    // ------------------------------------------------------------------
    // per-tick results and new events
    // ------------------------------------------------------------------
    logic [NTEST-1:0] warn_q;
    logic [NTEST-1:0] fail_q;
    logic [NTEST-1:0] evt_warn_q;
    logic [NTEST-1:0] evt_fail_q;
    logic [NTEST-1:0] fail_lat_q;
    logic diff_in_q;
    logic evt_diff_q;
    logic diff_dis_q;
    logic prot_dis_q;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            warn_q <= '0;
            fail_q <= '0;
            evt_warn_q <= '0;
            evt_fail_q <= '0;
        end else if (tick_q) begin
            warn_q <= warn_c;
            fail_q <= fail_raw;
            evt_warn_q <= warn_c & ~warn_q;
            evt_fail_q <= fail_raw & ~fail_q;
        end else begin
            evt_warn_q <= '0;
            evt_fail_q <= '0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            fail_lat_q <= '0;
            prot_dis_q <= 1'b0;
        end else begin
            fail_lat_q <= fail_lat_q | evt_fail_q;
            prot_dis_q <= prot_dis_q | (|evt_fail_q);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            diff_in_q <= 1'b0;
            evt_diff_q <= 1'b0;
            diff_dis_q <= 1'b0;
        end else begin
            diff_in_q <= diff_hw_fail_i;
            evt_diff_q <= diff_hw_fail_i && !diff_in_q;
            diff_dis_q <= diff_dis_q | evt_diff_q;
        end
    end

    // ------------------------------------------------------------------
    // alarm contact
    // ------------------------------------------------------------------
    logic [31:0] pulse_cnt_q;
    logic pulse_start;

    assign pulse_start = (|evt_warn_q) || evt_diff_q;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pulse_cnt_q <= 32'h00000000;
        end else if (pulse_start) begin
            pulse_cnt_q <= 32'(ALARM_PULSE);
        end else if (pulse_cnt_q != 32'h00000000) begin
            pulse_cnt_q <= pulse_cnt_q - 32'h00000001;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            alarm_energize_o <= 1'b1;
        end else begin
            alarm_energize_o <= !(prot_dis_q || pulse_cnt_q != 32'h00000000);
        end
    end

    // ------------------------------------------------------------------
    // protection outputs
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            output_contacts_o <= '0;
            overcurrent_enable_o <= 1'b0;
            trip_close_enable_o <= 1'b0;
            enabled_led_o <= 1'b0;
        end else begin
            output_contacts_o <= prot_dis_q ? '0 : out_req_i;
            overcurrent_enable_o <= !prot_dis_q;
            trip_close_enable_o <= !prot_dis_q;
            enabled_led_o <= !prot_dis_q;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            differential_output_contacts_o <= 6'h00;
            differential_protection_enabled_o <= 1'b0;
            differential_hardware_alarm_o <= 1'b0;
        end else begin
            differential_output_contacts_o <= (prot_dis_q || diff_dis_q) ? 6'h00 : diff_req_i;
            differential_protection_enabled_o <= !diff_dis_q;
            differential_hardware_alarm_o <= diff_dis_q;
        end
    end

    // ------------------------------------------------------------------
    // reports and display
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            status_report_o <= 1'b0;
            display_fail_o <= 1'b0;
            display_code_o <= 3'h0;
        end else begin
            status_report_o <= (|evt_warn_q) || (|evt_fail_q);
            display_fail_o <= |fail_lat_q;
            display_code_o <= first_set(fail_lat_q);
        end
    end

    // ------------------------------------------------------------------
    // negative-sequence restraint flag
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            negseq_restraint_flag_o <= 1'b0;
        end else begin
            negseq_restraint_flag_o <= nsq_i.remote_ma >= NSQ_PICKUP_MA
                                    && nsq_i.remote_ma < NSQ_DROPOUT_MA
                                    && abs_deg(nsq_i.angle_deg) >= NSQ_ANGLE_DEG;
        end
    end

    // ------------------------------------------------------------------
    // apb registers and interrupt
    // ------------------------------------------------------------------
    logic [STAT_W-1:0] status_q;
    logic [STAT_W-1:0] mask_q;
    logic [STAT_W-1:0] ev_vec;
    logic [STAT_W-1:0] w1c;
    logic wr_en;
    logic [31:0] rd_data;
    logic rd_err;

    assign wr_en = psel_i && penable_i && pready_o && pwrite_i;

    always_comb begin
        ev_vec = '0;
        ev_vec[WARN_LSB +: NTEST] = evt_warn_q;
        ev_vec[FAIL_LSB +: NTEST] = evt_fail_q;
        ev_vec[DIFF_BIT] = evt_diff_q;
        w1c = (wr_en && paddr_i == STATUS_OFS) ? pwdata_i[STAT_W-1:0] : '0;
    end

    always_comb begin
        rd_data = 32'h00000000;
        rd_err = 1'b0;
        if (paddr_i == STATUS_OFS) begin
            rd_data[STAT_W-1:0] = status_q;
        end else if (paddr_i == MASK_OFS) begin
            rd_data[STAT_W-1:0] = mask_q;
        end else if (paddr_i == CTRL_OFS) begin
            rd_data[CTRL_RUN_BIT] = run_q;
        end else if (paddr_i == LIVE_OFS) begin
            rd_data[WARN_LSB +: NTEST] = warn_q;
            rd_data[FAIL_LSB +: NTEST] = fail_q;
            rd_data[PROT_BIT] = prot_dis_q;
            rd_data[DDIS_BIT] = diff_dis_q;
            rd_data[ALRM_BIT] = !alarm_energize_o;
        end else begin
            rd_err = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            prdata_o <= 32'h00000000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= psel_i && penable_i && !pready_o;
            prdata_o <= (psel_i && penable_i && !pready_o && !pwrite_i) ? rd_data : 32'h00000000;
            pslverr_o <= psel_i && penable_i && !pready_o && rd_err;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            status_q <= '0;
            mask_q <= MASK_RST;
            run_q <= CTRL_RUN_RST;
        end else begin
            status_q <= (status_q & ~w1c) | ev_vec;
            if (wr_en && paddr_i == MASK_OFS) begin
                mask_q <= pwdata_i[STAT_W-1:0];
            end
            if (wr_en && paddr_i == CTRL_OFS) begin
                run_q <= pwdata_i[CTRL_RUN_BIT];
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_q & mask_q);
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_prot_disable_out: assert property (prot_dis_q |=> !enabled_led_o && !overcurrent_enable_o
        && !trip_close_enable_o && output_contacts_o == '0 && differential_output_contacts_o == 6'h00)
        else $error("protection disable left an output active");
    a_alarm_deenergize: assert property (|evt_fail_q |=> ##1 !alarm_energize_o [*3])
        else $error("failure did not deenergize alarm contact");
    a_alarm_pulse_end: assert property ((pulse_cnt_q == 32'h00000001 && !pulse_start && !prot_dis_q)
        ##1 (!pulse_start && !prot_dis_q) |=> alarm_energize_o)
        else $error("pulsed alarm did not end");
    a_alarm_pulse_load: assert property (pulse_start |=> pulse_cnt_q == 32'(ALARM_PULSE) ##1 !alarm_energize_o)
        else $error("pulsed alarm not started");
    a_diff_disable: assert property (evt_diff_q |=> ##1 !differential_protection_enabled_o
        && differential_hardware_alarm_o && differential_output_contacts_o == 6'h00)
        else $error("differential disable incomplete");
    a_report_event: assert property ((|evt_warn_q || |evt_fail_q) |=> status_report_o)
        else $error("no status report for new event");
    a_fail_display: assert property ((|evt_fail_q) |=> ##1 display_fail_o)
        else $error("failure not displayed");
    a_warn_nodisplay: assert property (fail_lat_q == '0 |=> !display_fail_o)
        else $error("display shows failure without one");
    a_chan_warn: assert property (tick_q && |chan_over && !prot_dis_q && fail_raw == '0
        |=> warn_q[T_CHOFS] ##1 !prot_dis_q)
        else $error("channel offset warning wrong");
    a_master_fail: assert property (tick_q && meas_i.master_ofs_mv > MOFS_FAIL_MV
        |=> fail_q[T_MOFS] && !warn_q[T_MOFS] ##1 prot_dis_q)
        else $error("master offset failure missed");
    a_p5_fail: assert property (tick_q && meas_i.p5_mv > P5_FAIL_HI |=> fail_q[T_P5])
        else $error("5 V failure missed");
    a_reg5_warn: assert property (tick_q && meas_i.reg_neg_mv == REGN_WARN_HI + 16'd1
        && !fail_raw[T_REG5] |=> warn_q[T_REG5])
        else $error("regulated 5 V warning missed");
    a_p12_fail: assert property (tick_q && meas_i.p12_neg_mv < P12_FAIL_LO |=> fail_q[T_P12])
        else $error("12 V failure missed");
    a_p15_warn: assert property (tick_q && meas_i.p15_pos_mv == P15_WARN_LO - 16'd1
        && !fail_raw[T_P15] |=> warn_q[T_P15] && !fail_q[T_P15])
        else $error("15 V warning missed");
    a_negseq_block: assert property (abs_deg(nsq_i.angle_deg) <= NSQ_BLOCK_DEG
        |=> !negseq_restraint_flag_o)
        else $error("restraint flag inside blocked angles");
    a_negseq_drop: assert property (nsq_i.remote_ma >= NSQ_DROPOUT_MA |=> !negseq_restraint_flag_o)
        else $error("restraint flag above dropout");
    a_negseq_angle: assert property (nsq_i.remote_ma == nsq_i.local_ma && nsq_i.remote_ma >= NSQ_PICKUP_MA
        && nsq_i.remote_ma < NSQ_DROPOUT_MA && abs_deg(nsq_i.angle_deg) >= 8'd85 |=> negseq_restraint_flag_o)
        else $error("restraint flag missing at wide angle");
    a_fail_over_warn: assert property ((warn_q & fail_q) == '0)
        else $error("warning and failure both set");

    c_warn_pulse: cover property (pulse_start ##1 pulse_cnt_q != 32'h00000000);
    c_fail_latch: cover property ($rose(prot_dis_q));
    c_diff_off: cover property ($rose(differential_hardware_alarm_o));
    c_negseq_on: cover property ($rose(negseq_restraint_flag_o));

endmodule : rsts_top

// ==== rsts_mon.sv ====
// monitor model: supply and offset levels seen by the self-test supervisor
// assumes fault_i is changed by the bench just after a clock edge
`timescale 1ns/1ps
module rsts_mon
    import rsts_pkg::*;
(
    input wire logic [1:0] fault_i,
    output rsts_pkg::rsts_meas_s meas_o
);
    // 1: channel offset and +5 V just outside warning, 2: master offset failure
    // 3: regulated -5 V and +15 V just outside warning, -12 V just below failure
    always_comb begin
        meas_o = '0;
        meas_o.chan_ofs_mv[0] = (fault_i == 2'h1) ? 16'h001F : 16'h001E;
        meas_o.master_ofs_mv = (fault_i == 2'h2) ? 16'h0028 : 16'h0005;
        meas_o.p5_mv = (fault_i == 2'h1) ? 16'h12BF : 16'h1388;
        meas_o.reg_pos_mv = 16'h1388;
        meas_o.reg_neg_mv = (fault_i == 2'h3) ? 16'h1483 : 16'h1388;
        meas_o.p12_pos_mv = 16'h2EE0;
        meas_o.p12_neg_mv = (fault_i == 2'h3) ? 16'h2BBF : 16'h2EE0;
        meas_o.p15_pos_mv = (fault_i == 2'h3) ? 16'h383F : 16'h3A98;
        meas_o.p15_neg_mv = 16'h3A98;
    end
endmodule : rsts_mon

// ==== testbench.sv ====
// self-checking bench of the relay self-test supervisor
// assumes rsts_pkg, rsts_top and rsts_mon are compiled first
`timescale 1ns/1ps
module testbench;
    import rsts_pkg::*;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, hw = 0, pready, perr, e;
    logic oce, tce, led, alm, dpe, dha, rep, dfl, flag, irq;
    logic [7:0] pa = 8'h00, oc;
    logic [31:0] pd = 32'h0, prd, r;
    logic [1:0] flt = 2'h0;
    logic [5:0] dc;
    logic [2:0] code;
    rsts_nsq_s nsq = '0;
    rsts_meas_s meas;
    int fails = 0, n_compared = 0;
    always #25 clk = ~clk;
    rsts_mon rsts_mon_i (.fault_i(flt), .meas_o(meas));
    rsts_top #(.TEST_PERIOD(50), .ALARM_PULSE(20)) rsts_top_i (.ref_clk_i(clk), .rst_i(rst), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pw), .paddr_i(pa), .pwdata_i(pd), .prdata_o(prd), .pready_o(pready),
        .pslverr_o(perr), .meas_i(meas), .nsq_i(nsq), .diff_hw_fail_i(hw), .out_req_i(8'hFF),
        .diff_req_i(6'h3F), .output_contacts_o(oc), .differential_output_contacts_o(dc),
        .overcurrent_enable_o(oce), .trip_close_enable_o(tce), .enabled_led_o(led), .alarm_energize_o(alm),
        .differential_protection_enabled_o(dpe), .differential_hardware_alarm_o(dha), .status_report_o(rep),
        .display_fail_o(dfl), .display_code_o(code), .negseq_restraint_flag_o(flag), .irq_o(irq));
    task chk(input logic [31:0] s, input logic [31:0] x);
        n_compared++;
        if (s !== x) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, x);
        end
    endtask : chk
    task results;
        if (fails == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pw <= w;
        pa <= a;
        pd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    task wrep;
        for (int i = 0; i < 200 && rep !== 1'b1; i++) @(posedge clk);
        chk(rep, 1'b1);
    endtask : wrep
    task ns(input logic [15:0] lo, input logic [15:0] rm, input logic [8:0] an, input logic x);
        nsq <= '{lo, rm, an};
        repeat (3) @(posedge clk);
        chk(flag, x);
    endtask : ns
    task t_regs;
        apb(1'b0, CTRL_OFS, 32'h0);
        chk(r, 32'h1);
        apb(1'b1, CTRL_OFS, 32'h0);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk(r, 32'h0);
        apb(1'b1, CTRL_OFS, 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk(e, 1'b1);
        apb(1'b1, MASK_OFS, 32'hFFFFFFFF);
        apb(1'b0, MASK_OFS, 32'h0);
        chk(r, 32'h1FFFF);
    endtask : t_regs
    task t_nsq;
        ns(16'h091A, 16'h0190, 9'h0B4, 1'b1);
        ns(16'h091A, 16'h012C, 9'h0B4, 1'b0);
        ns(16'h091A, 16'h0190, 9'h1C4, 1'b0);
        ns(16'h091A, 16'h38A4, 9'h0B4, 1'b0);
        ns(16'h091A, 16'h34BC, 9'h19C, 1'b1);
        ns(16'h1388, 16'h1388, 9'h055, 1'b1);
        ns(16'h1388, 16'h1388, 9'h1AB, 1'b1);
        ns(16'h1388, 16'h1388, 9'h050, 1'b0);
    endtask : t_nsq
    task t_warn;
        flt <= 2'h1;
        wrep;
        chk(oce, 1'b1);
        @(posedge clk);
        chk(alm, 1'b0);
        chk(dfl, 1'b0);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(r, 32'h5);
        chk(irq, 1'b1);
        apb(1'b1, STATUS_OFS, 32'h5);
        repeat (25) @(posedge clk);
        chk(alm, 1'b1);
        chk(irq, 1'b0);
    endtask : t_warn
    task t_diff;
        hw <= 1'b1;
        repeat (6) @(posedge clk);
        chk({dpe, dha, dc, oc}, 16'h40FF);
        chk(alm, 1'b0);
    endtask : t_diff
    task t_fail;
        flt <= 2'h2;
        wrep;
        @(posedge clk);
        chk({oce, tce, led, oc}, 11'h000);
        repeat (2) @(posedge clk);
        chk({dfl, code}, 4'h9);
        apb(1'b0, LIVE_OFS, 32'h0);
        chk(r, 32'h70200);
        repeat (30) @(posedge clk);
        chk(alm, 1'b0);
        flt <= 2'h3;
        wrep;
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(r, 32'h11228);
        apb(1'b0, LIVE_OFS, 32'h0);
        chk(r, 32'h71028);
    endtask : t_fail
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs;
        t_nsq;
        t_warn;
        t_diff;
        t_fail;
        results;
    end
    initial begin
        #100000;
        fails++;
        results;
    end
endmodule : testbench
